// [hdl/spi_chip_select_timing.sv]
// Overview of operation
// RULE1: Mirror register returns received word in bits 15:0 without touching flags.
// RULE2: Setup delay is setup field plus two module clocks before first clock edge.
// RULE3: Setup field zero means no setup delay at all.
// RULE4: Clock phase one adds half a bit period before first clock edge.
// RULE5: Hold delay is hold field plus one module clock after the last bit.
// RULE6: Hold field zero means no hold delay at all.
// RULE7: Clock phase zero adds half a bit period before chip select release.
// RULE8: Setup counting ignores the slave enable line.
// RULE9: Hold counting ignores early enable release; chip select stays active.
// RULE10: Software keeps setup and hold values as small as slaves allow.
// RULE11: Enable still active past end-of-transfer time-out sets desync flag.
// RULE12: Enable released before transfer end sets desync flag; the code checks this only while shifting with the wait-for-enable option set.
// RULE13: End-of-transfer time-out counts serial bit clock periods of current format.
// RULE14: Desync flag raises interrupt request only when its enable is set.
// RULE15: Wait for enable after chip select bounded by response time-out field.
// RULE16: Response time-out sets time-out flag, interrupt request only when enabled.
// RULE17: Idle chip select pins follow idle pattern bits directly.
// RULE18: During transfer pins follow chip select number; hold bit keeps them active.
// RULE19: Software sets idle pattern to all ones in slave mode.
// RULE20: Software writes zero to idle bits of absent pins.
// RULE21: Response time-out releases chip select immediately.
// RULE22: Wait-for-enable failure aborts the transfer.
// RULE23: Format timer-disable bit skips both setup and hold delays.
// RULE24: All counters restart from zero at each activation and transfer end.
`timescale 1ns/10ps

module spi_chip_select_timing
    import cs_timing_pkg::*;
#(
    parameter int cs_width = 8
) (
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // Avalon-MM slave
    input wire logic [3:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [3:0] byteenable,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    // Shift engine side
    input wire logic [15:0] received_word,
    input wire logic [31:0] format_word,
    input wire logic shift_done,
    input wire logic desync_int_enable,
    input wire logic timeout_int_enable,
    output logic shift_start,
    output logic transfer_abort,
    output logic desync_flag,
    output logic timeout_flag,
    output logic desync_irq,
    output logic timeout_irq,
    // Pins
    input wire logic serial_bit_clock,
    input wire logic slave_enable_line_n,
    output logic [cs_width-1:0] chip_select_pins
);

    // --------------------------------------------------------------
    // Synchronisers for the link clock and the enable pin
    // --------------------------------------------------------------
    logic [2:0] sclk_sync_reg;
    logic [1:0] ena_sync_reg;
    logic sclk_rise;
    logic ena_active;

    // Third stage only feeds the edge detector, never the first stage
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            sclk_sync_reg <= 3'h0;
            ena_sync_reg <= 2'h3;
        end else begin
            sclk_sync_reg <= {sclk_sync_reg[1:0], serial_bit_clock};
            ena_sync_reg <= {ena_sync_reg[0], slave_enable_line_n};
        end
    end

    assign sclk_rise = sclk_sync_reg[1] & ~sclk_sync_reg[2];
    assign ena_active = ~ena_sync_reg[1];

    // --------------------------------------------------------------
    // Register file
    // --------------------------------------------------------------
    logic [31:0] delay_reg;
    logic [7:0] idle_reg;
    logic [7:0] chip_select_number_field_reg;
    logic hold_active_bit_reg;
    logic start_reg;
    logic rd_pending_reg;

    // Merge byte lanes of a write into an old word
    function automatic logic [31:0] lane_merge(input logic [31:0] old,
                                               input logic [31:0] wd,
                                               input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return r;
    endfunction : lane_merge

    // Writes take effect at once; start bit is a one-cycle request
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            delay_reg <= delay_reset;
            idle_reg <= idle_reset;
            chip_select_number_field_reg <= idle_reset;
            hold_active_bit_reg <= 1'b0;
            start_reg <= 1'b0;
        end else begin
            start_reg <= 1'b0;
            if (write) begin
                case (address)
                    addr_delay: delay_reg <= lane_merge(delay_reg, writedata, byteenable);
                    addr_idle: begin
                        if (byteenable[0]) begin
                            idle_reg <= writedata[7:0];
                        end
                    end
                    addr_xfer: begin
                        if (byteenable[2]) begin
                            chip_select_number_field_reg <= writedata[chip_select_number_field_lsb +: 8];
                        end
                        if (byteenable[3]) begin
                            hold_active_bit_reg <= writedata[hold_active_bit_bit];
                            start_reg <= writedata[start_bit];
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // Reads answer one cycle after the request; writes need no wait
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rd_pending_reg <= 1'b0;
        end else begin
            rd_pending_reg <= read & ~rd_pending_reg;
        end
    end

    assign waitrequest = read & ~rd_pending_reg;

    logic [2:0] state_reg;

    // Mirror read has no side effect on any flag
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            readdata <= 32'h0000_0000;
        end else if (read & ~rd_pending_reg) begin
            case (address)
                addr_mirror: readdata <= {16'h0000, received_word}; // RULE1
                addr_delay: readdata <= delay_reg;
                addr_idle: readdata <= {24'h000000, idle_reg};
                addr_xfer: readdata <= {start_reg, 2'h0, hold_active_bit_reg, 4'h0, chip_select_number_field_reg,
                                        5'h00, state_reg, desync_flag, timeout_flag, 6'h00};
                default: readdata <= 32'h0000_0000;
            endcase
        end
    end

    // --------------------------------------------------------------
    // Chip select sequencer
    // --------------------------------------------------------------
    cs_state_e state_q;
    logic [8:0] count_reg;
    logic [7:0] sclk_count_reg;
    logic half_pending_reg;
    logic timers_off;
    logic [7:0] setup_field;
    logic [7:0] hold_field;
    logic [7:0] eot_field;
    logic [7:0] resp_field;
    logic eot_watch_reg;

    assign state_reg = state_q;
    assign timers_off = format_word[distimer_bit]; // RULE23
    assign setup_field = delay_reg[setup_lsb +: 8];
    assign hold_field = delay_reg[hold_lsb +: 8];
    assign eot_field = delay_reg[eot_lsb +: 8];
    assign resp_field = delay_reg[resp_lsb +: 8];

    // Counters reset on entry to each state that uses them so no value carries over
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= st_idle;
            count_reg <= 9'h000;
            sclk_count_reg <= 8'h00;
            half_pending_reg <= 1'b0;
            shift_start <= 1'b0;
            transfer_abort <= 1'b0;
            timeout_flag <= 1'b0;
        end else begin
            shift_start <= 1'b0;
            transfer_abort <= 1'b0;
            count_reg <= count_reg + 9'h001;
            if (sclk_rise) begin
                sclk_count_reg <= sclk_count_reg + 8'h01;
            end
            if (write && address == addr_xfer && byteenable[3] && writedata[29]) begin
                timeout_flag <= 1'b0;
            end
            case (state_q)
                st_idle: begin
                    if (start_reg) begin
                        state_q <= st_setup; // RULE24
                        count_reg <= 9'h001;
                        sclk_count_reg <= 8'h00;
                        timeout_flag <= timeout_flag;
                    end
                end
                st_setup: begin
                    // Enable line is not looked at here
                    if (timers_off || setup_field == 8'h00 || // RULE3 RULE8
                        count_reg >= {1'b0, setup_field} + 9'h002) begin // RULE2
                        state_q <= format_word[wait_for_enable_option_bit] ? st_wait : st_shift;
                        half_pending_reg <= format_word[phase_bit]; // RULE4
                        count_reg <= 9'h000;
                        sclk_count_reg <= 8'h00;
                        shift_start <= ~format_word[wait_for_enable_option_bit] & ~format_word[phase_bit];
                    end
                end
                st_wait: begin
                    if (ena_active) begin
                        state_q <= st_shift;
                        shift_start <= ~half_pending_reg;
                        sclk_count_reg <= 8'h00;
                    end else if (sclk_count_reg >= resp_field) begin // RULE15
                        timeout_flag <= 1'b1; // RULE16
                        transfer_abort <= 1'b1; // RULE22
                        state_q <= st_idle; // RULE21
                    end
                end
                st_shift: begin
                    // Half bit delay measured from one bit clock edge
                    if (half_pending_reg && sclk_count_reg != 8'h00) begin
                        half_pending_reg <= 1'b0;
                        shift_start <= 1'b1;
                    end
                    if (shift_done) begin
                        state_q <= format_word[phase_bit] ? st_hold : st_half; // RULE7
                        count_reg <= 9'h001;
                        sclk_count_reg <= 8'h00;
                    end
                end
                st_half: begin
                    if (sclk_count_reg != 8'h00) begin
                        state_q <= st_hold;
                        count_reg <= 9'h001;
                    end
                end
                st_hold: begin
                    // Early enable release does not shorten the hold
                    if (timers_off || hold_field == 8'h00 || // RULE6 RULE9
                        count_reg >= {1'b0, hold_field} + 9'h001) begin // RULE5
                        state_q <= st_idle;
                        count_reg <= 9'h000;
                    end
                end
                default: state_q <= st_idle;
            endcase
        end
    end

    // --------------------------------------------------------------
    // Desynchronisation watch
    // --------------------------------------------------------------
    logic [7:0] eot_count_reg;

    // Set wins over a clear in the same cycle
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            desync_flag <= 1'b0;
            eot_watch_reg <= 1'b0;
            eot_count_reg <= 8'h00;
        end else begin
            if (sclk_rise) begin
                eot_count_reg <= eot_count_reg + 8'h01; // RULE13
            end
            if (state_q == st_hold && (timers_off || hold_field == 8'h00 ||
                count_reg >= {1'b0, hold_field} + 9'h001)) begin
                eot_watch_reg <= 1'b1;
                eot_count_reg <= 8'h00; // RULE24
            end else if (eot_watch_reg && !ena_active) begin
                eot_watch_reg <= 1'b0;
            end
            if (write && address == addr_xfer && byteenable[3] && writedata[30]) begin
                desync_flag <= 1'b0;
            end
            if (eot_watch_reg && ena_active && eot_count_reg >= eot_field) begin
                desync_flag <= 1'b1; // RULE11
                eot_watch_reg <= 1'b0;
            end
            if (state_q == st_shift && format_word[wait_for_enable_option_bit] && !ena_active) begin
                desync_flag <= 1'b1; // RULE12
            end
        end
    end

    // Interrupt requests gated by enables from the flag logic
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            desync_irq <= 1'b0;
            timeout_irq <= 1'b0;
        end else begin
            desync_irq <= desync_flag & desync_int_enable; // RULE14
            timeout_irq <= timeout_flag & timeout_int_enable; // RULE16
        end
    end

    // --------------------------------------------------------------
    // Chip select pins
    // --------------------------------------------------------------
    // Pins are registered so they never glitch while the state decodes.
    // Idle pattern drives the pins when no transfer is running, unless hold-active is set.
    // A response time-out forces the idle pattern at once, even mid-wait.
    // The hold-active bit keeps the transfer pattern between transfers,
    // but a pending time-out overrides it so a mute slave is released.
    // Limitation: the pin update lags the state by one module clock,
    // which takes one cycle off the setup and adds one to the hold as seen on the pins.
    // Only the low cs_width bits of either pattern reach the pins.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            chip_select_pins <= {cs_width{1'b1}};
        end else if (state_q == st_idle && !(hold_active_bit_reg && !timeout_flag)) begin
            chip_select_pins <= idle_reg[cs_width-1:0]; // RULE17
        end else if (state_q == st_wait && sclk_count_reg >= resp_field && !ena_active) begin
            chip_select_pins <= idle_reg[cs_width-1:0]; // RULE21
        end else if (state_q != st_idle || hold_active_bit_reg) begin
            chip_select_pins <= chip_select_number_field_reg[cs_width-1:0]; // RULE18
        end
    end

endmodule : spi_chip_select_timing

// [hdl/cs_timing_pkg.sv]
package cs_timing_pkg;

    // --------------------------------------------------------------
    // Register map (byte addresses, one word each)
    // --------------------------------------------------------------
    localparam logic [3:0] addr_mirror = 4'h0;
    localparam logic [3:0] addr_delay = 4'h4;
    localparam logic [3:0] addr_idle = 4'h8;
    localparam logic [3:0] addr_xfer = 4'hc;
    localparam logic [3:0] addr_status = 4'h0 + 4'h0 + 4'h0 + 4'h0;
    localparam logic [3:0] addr_flags = 4'h0;

    // --------------------------------------------------------------
    // Field positions
    // --------------------------------------------------------------
    localparam int setup_lsb = 24;
    localparam int hold_lsb = 16;
    localparam int eot_lsb = 8;
    localparam int resp_lsb = 0;
    localparam int chip_select_number_field_lsb = 16;
    localparam int start_bit = 31;
    localparam int hold_active_bit_bit = 28;
    localparam int wait_for_enable_option_bit = 21;
    localparam int distimer_bit = 18;
    localparam int phase_bit = 16;
    localparam int bits_lsb = 8;

    // --------------------------------------------------------------
    // Reset values
    // --------------------------------------------------------------
    localparam logic [31:0] delay_reset = 32'h0000_0000;
    localparam logic [7:0] idle_reset = 8'hff;

    // Controller states, Gray along idle-setup-wait-shift-hold
    typedef enum logic [2:0] {
        st_idle = 3'b000,
        st_setup = 3'b001,
        st_wait = 3'b011,
        st_shift = 3'b010,
        st_hold = 3'b110,
        st_half = 3'b111
    } cs_state_e;

endpackage : cs_timing_pkg

// [verification/cs_timing_sva.sv]
`timescale 1ns/10ps
// ------
// Checker
// ------
module cs_timing_sva
    import cs_timing_pkg::*;
#(
    parameter int cs_width = 8
) (
    // Clock, reset and register bus
    input wire logic clock,
    input wire logic reset_n,
    input wire logic [3:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [3:0] byteenable,
    input wire logic [31:0] writedata,
    input wire logic [31:0] readdata,
    input wire logic waitrequest,
    // Shift engine side and pins
    input wire logic [15:0] received_word,
    input wire logic [31:0] format_word,
    input wire logic desync_int_enable,
    input wire logic timeout_int_enable,
    input wire logic shift_start,
    input wire logic transfer_abort,
    input wire logic desync_flag,
    input wire logic timeout_flag,
    input wire logic desync_irq,
    input wire logic timeout_irq,
    input wire logic [cs_width-1:0] chip_select_pins
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);
    logic start_w;
    logic [7:0] setup_reg;
    logic [9:0] since_reg;
    assign start_w = write && address == addr_xfer && byteenable[3] && writedata[start_bit];
    // Shadow of the setup field; only a lower bound is kept, the exact launch is the bench's
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) setup_reg <= 8'h00;
        else if (write && address == addr_delay && byteenable[3]) setup_reg <= writedata[31:24];
    end
    // Age of the last start request, saturating so it never wraps into a false pass
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) since_reg <= 10'h3ff;
        else if (start_w) since_reg <= 10'h000;
        else if (since_reg != 10'h3ff) since_reg <= since_reg + 10'h001;
    end
    mirror_data_a: assert property (read && address == addr_mirror && !waitrequest |->
        readdata == {16'h0000, received_word}) else $error("mirror read data wrong");
    mirror_flags_a: assert property (read && address == addr_mirror |=>
        !$fell(desync_flag) && !$fell(timeout_flag)) else $error("mirror read cleared a flag");
    setup_min_a: assert property (shift_start && setup_reg != 8'h00 &&
        !format_word[distimer_bit] |-> since_reg > {2'b00, setup_reg}) else $error("setup short");
    no_setup_a: assert property (start_w && format_word[distimer_bit] &&
        !format_word[wait_for_enable_option_bit] && !format_word[phase_bit] |-> ##[1:5] shift_start)
        else $error("setup not skipped");
    timeout_release_a: assert property ($rose(timeout_flag) |->
        ##[0:2] chip_select_pins == {cs_width{1'b1}}) else $error("select kept after time-out");
    abort_cause_a: assert property (transfer_abort |-> ##[0:1] timeout_flag)
        else $error("abort without time-out");
    desync_irq_a: assert property (desync_flag && desync_int_enable |=> desync_irq)
        else $error("desync request missing");
    timeout_irq_a: assert property (timeout_irq |->
        $past(timeout_flag) && $past(timeout_int_enable)) else $error("time-out request wrong");
    cover property (shift_start);
    cover property ($rose(timeout_flag));
    cover property ($rose(desync_flag));
endmodule : cs_timing_sva
bind spi_chip_select_timing cs_timing_sva #(.cs_width(cs_width)) cs_timing_sva_i (.*);

// [verification/spi_slave_model.sv]
`timescale 1ns/10ps
// ------
// Slave with enable handshake
// ------
module spi_slave_model (
    // Clock, reset and behaviour: 0 prompt, 1 mute, 2 early drop, 3 late release
    input wire logic clock,
    input wire logic reset_n,
    input wire logic [1:0] mode,
    // Pins
    input wire logic [7:0] chip_select_pins,
    output logic slave_enable_line_n
);
    logic sel;
    logic sel_reg;
    logic [7:0] age_reg;
    assign sel = chip_select_pins != 8'hff;
    // Cycles since the last select edge; the handshake is timed from it
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            sel_reg <= 1'b0;
            age_reg <= 8'h00;
        end else begin
            sel_reg <= sel;
            age_reg <= (sel != sel_reg) ? 8'h00 : age_reg + {7'h00, age_reg != 8'hff};
        end
    end
    // Enable has a pull-up, so a released line reads high; mode 3 holds the last value for 40 cycles
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) slave_enable_line_n <= 1'b1;
        else if (sel) slave_enable_line_n <= !(mode != 2'h1 && age_reg >= 8'h02 &&
            (mode != 2'h2 || age_reg < 8'h06));
        else if (mode != 2'h3 || age_reg >= 8'h28) slave_enable_line_n <= 1'b1;
    end
endmodule : spi_slave_model

// [verification/tb_spi_chip_select_timing.sv]
`timescale 1ns/10ps
// ------
// Bench
// ------
module tb_spi_chip_select_timing import cs_timing_pkg::*;;
    logic clock, reset_n, read, write, shift_done, desync_int_enable, timeout_int_enable;
    logic waitrequest, shift_start, transfer_abort, desync_flag, timeout_flag, aborted;
    logic desync_irq, timeout_irq, serial_bit_clock, slave_enable_line_n;
    logic [3:0] address, byteenable;
    logic [31:0] writedata, readdata, format_word, rdata;
    logic [15:0] received_word;
    logic [7:0] chip_select_pins;
    logic [1:0] mode;
    int fails, n_compared, su, hd;
    typedef struct packed {logic [3:0] a; logic w; logic [31:0] d, e; logic [7:0] p;} row_s;
    // Address, write, data, read-back, idle pins
    row_s rows [7] = '{'{addr_mirror, 1'b0, 32'h0, 32'h0000_5a3c, 8'hff},
        '{addr_delay, 1'b0, 32'h0, 32'h0, 8'hff}, '{addr_idle, 1'b0, 32'h0, 32'hff, 8'hff},
        '{addr_delay, 1'b1, 32'h0102_0304, 32'h0102_0304, 8'hff},
        '{addr_idle, 1'b1, 32'h0000_003c, 32'h3c, 8'h3c},
        '{addr_idle, 1'b1, 32'hff, 32'hff, 8'hff}, '{4'h2, 1'b1, 32'hffff_ffff, 32'h0, 8'hff}};
    spi_chip_select_timing #(.cs_width(8)) spi_chip_select_timing_i (.*);
    spi_slave_model spi_slave_model_i (.*);
    // Module clock, and a free-running bit clock of unrelated phase
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    initial begin
        serial_bit_clock = 1'b0;
        #137;
        forever #400 serial_bit_clock = ~serial_bit_clock;
    end
    // Watchdog: the whole run needs well under a tenth of this
    initial begin
        #3000000;
        fails++;
        summarize();
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic inr(input int v, input int lo, input int hi);
        check({31'h0, v >= lo && v <= hi}, 32'h1);
    endtask : inr
    // One Avalon cycle, held until waitrequest is sampled low
    task automatic bus(input logic [3:0] a, input logic w, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clock);
        address <= a;
        read <= !w;
        write <= w;
        writedata <= d;
        byteenable <= 4'hf;
        do begin
            @(posedge clock);
            k++;
        end while (waitrequest !== 1'b0 && k < 20);
        rdata = readdata;
        read <= 1'b0;
        write <= 1'b0;
        if (k >= 20) fails++;
    endtask : bus
    // Program delays, start, play the shift engine, then time the release
    task automatic xfer(input logic [31:0] dly, fmt, ctl, input logic [1:0] m);
        format_word <= fmt;
        mode <= m;
        bus(addr_delay, 1'b1, dly);
        bus(addr_xfer, 1'b1, ctl);
        su = 0;
        aborted = 1'b0;
        while (shift_start !== 1'b1 && !aborted && su < 300) begin
            @(posedge clock);
            su++;
            aborted = transfer_abort === 1'b1;
        end
        if (!aborted) begin
            check({24'h0, chip_select_pins}, {24'h0, ctl[23:16]});
            repeat (20) @(posedge clock);
            shift_done <= 1'b1;
            @(posedge clock);
            shift_done <= 1'b0;
        end
        hd = 0;
        while (chip_select_pins !== 8'hff && hd < 80) begin
            @(posedge clock);
            hd++;
        end
        $display("transfer done setup=%0d hold=%0d", su, hd);
    endtask : xfer
    task automatic summarize();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : summarize
    // Main sequence
    initial begin
        {reset_n, read, write, shift_done, address, byteenable, writedata} = '0;
        {format_word, mode, desync_int_enable, timeout_int_enable} = '0;
        received_word = 16'h5a3c;
        fails = 0;
        n_compared = 0;
        repeat (20) @(posedge clock);
        reset_n <= 1'b1;
        foreach (rows[i]) begin
            if (rows[i].w) bus(rows[i].a, 1'b1, rows[i].d);
            bus(rows[i].a, 1'b0, 32'h0);
            check(rdata, rows[i].e);
            check({24'h0, chip_select_pins}, {24'h0, rows[i].p});
        end
        $display("register rows done");
        xfer(32'h0320_0808, 32'h0, 32'h80fe_0000, 2'h0);
        inr(su, 5, 9);
        inr(hd, 34, 52);
        xfer(32'h0320_0808, 32'h0001_0000, 32'h80fe_0000, 2'h0);
        inr(su, 6, 30);
        inr(hd, 32, 37);
        xfer(32'h0320_0808, 32'h0004_0000, 32'h80fe_0000, 2'h0);
        inr(su + hd, 0, 23);
        xfer(32'h0000_0808, 32'h0, 32'h80fe_0000, 2'h0);
        inr(su, 0, 3);
        inr(hd, 0, 20);
        check({desync_flag, timeout_flag}, 32'h0);
        xfer(32'h0000_0808, 32'h0, 32'h90fb_0000, 2'h0);
        check({24'h0, chip_select_pins}, 32'hfb);
        xfer(32'h0000_0808, 32'h0, 32'h80fe_0000, 2'h0);
        inr(hd, 0, 20);
        timeout_int_enable <= 1'b1;
        xfer(32'h0000_0802, 32'h0020_0000, 32'h80fe_0000, 2'h1);
        inr(su, 8, 40);
        repeat (3) @(posedge clock);
        check({aborted, timeout_flag, timeout_irq, chip_select_pins}, 32'h7ff);
        bus(addr_xfer, 1'b1, 32'h2000_0000);
        xfer(32'h0020_0808, 32'h0020_0000, 32'h80fe_0000, 2'h2);
        inr(hd, 33, 52);
        bus(addr_mirror, 1'b0, 32'h0);
        check({desync_flag, desync_irq, timeout_flag, 13'h0000, rdata[15:0]}, 32'h8000_5a3c);
        bus(addr_xfer, 1'b1, 32'h4000_0000);
        desync_int_enable <= 1'b1;
        xfer(32'h0000_0208, 32'h0, 32'h80fe_0000, 2'h3);
        repeat (40) @(posedge clock);
        check({desync_flag, desync_irq}, 32'h3);
        $display("handshake tests done");
        reset_n <= 1'b0;
        repeat (2) @(posedge clock);
        check({desync_flag, timeout_flag, chip_select_pins}, 32'hff);
        reset_n <= 1'b1;
        bus(addr_delay, 1'b0, 32'h0);
        check(rdata, 32'h0);
        summarize();
    end
endmodule : tb_spi_chip_select_timing
